// ==== inc/msr_pkg.sv ====
`default_nettype none
package msr_pkg;
	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0]  ADDR_PROGRESS    = 8'h02;
	localparam logic [7:0]  ADDR_SUPPLY      = 8'h03;
	localparam logic [7:0]  ADDR_CLOCK       = 8'h04;
	localparam logic [15:0] RST_PROGRESS     = 16'h0000;
	localparam logic [15:0] RST_SUPPLY       = 16'hffff;
	localparam logic [15:0] RST_CLOCK        = 16'hfc07;
	// fixed upper bits of the clock fault register, bits 15:3
	localparam logic [12:0] CLOCK_FIXED_BITS = 13'h1f80;
	localparam logic [1:0]  CNT_RESET        = 2'h0;
	localparam logic [1:0]  CNT_STEP         = 2'h1;

	// ----------------------------------------------------------------
	// field positions of the progress register
	// ----------------------------------------------------------------
	localparam int POS_AUX_SEQ_CNT = 14;
	localparam int POS_CUR_A_CNT   = 10;
	localparam int POS_CUR_B_CNT   = 8;
	localparam int POS_AUX_RUN     = 1;

	// ----------------------------------------------------------------
	// supply fault bit positions, all active low
	// ----------------------------------------------------------------
	localparam int POS_ANALOG_OV   = 15;
	localparam int POS_ANALOG_UV   = 14;
	localparam int POS_IO_OV       = 13;
	localparam int POS_IO_UV       = 12;
	localparam int POS_CORE_OV     = 11;
	localparam int POS_CORE_UV     = 10;
	localparam int POS_ANALOG_OSC  = 9;
	localparam int POS_IO_OSC      = 8;
	localparam int POS_CORE_OSC    = 7;
	localparam int POS_ANALOG_HOT  = 6;
	localparam int POS_IO_HOT      = 5;
	localparam int POS_ANALOG_LIM  = 4;
	localparam int POS_IO_LIM      = 3;
	localparam int POS_AGND1_OPEN  = 2;
	localparam int POS_AGND2_OPEN  = 1;
	localparam int POS_DIGITAL_GROUND_OPEN   = 0;

	// converter completion events and enables
	typedef struct packed {
		logic aux_seq_done;
		logic aux_seq_running;
		logic current_a_done;
		logic current_b_done;
		logic aux_enable;
		logic current_a_enable;
		logic current_b_enable;
		logic standby;
	} msr_conv_type;

	// register port request
	typedef struct packed {
		logic [7:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} msr_bus_type;
endpackage
`default_nettype wire

// ==== hw/msr_status_regs.sv ====
`default_nettype none
module msr_status_regs (
	input  wire logic                  i_clock,
	input  wire logic                  i_rst_n,
	input  wire msr_pkg::msr_conv_type i_conv,
	input  wire logic [15:0]           i_supply_fault,
	input  wire logic [2:0]            i_clock_fault,
	input  wire msr_pkg::msr_bus_type  i_bus,
	output logic [15:0]                o_rdata,
	output logic [15:0]                o_progress,
	output logic [15:0]                o_supply_flags
);
	// ----------------------------------------------------------------
	// latency and hazards
	// ----------------------------------------------------------------
	// raw fault levels take three edges to reach a flag: two
	// synchroniser stages and the flag itself. a fault pulse shorter
	// than one clock period may be missed entirely; the monitors are
	// expected to hold their level for at least one period.
	// when a synchronised fault and a host clear meet in one cycle the
	// fault wins, so software never loses a fault it has not yet seen.
	// the host should read the flag again after a clear: a fault that
	// is still present pulls the flag straight back to zero.
	// completion counters are only two bits wide. software must read
	// them faster than four completions apart or it will lose counts.
	// that is the price of a status word that fits one read.
	// a disable or standby level clears a counter even in the cycle of
	// a completion, so a stale count never survives a restart.
	// the progress register ignores host writes; its contents follow
	// the converters only.
	// o_progress and o_supply_flags are registered copies, one cycle
	// behind the read path, for neighbouring logic that wants status
	// without going through the register port.
	// aux configuration writes while the aux converter runs are the
	// host's duty to avoid; nothing here blocks or reports them.

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	// fault levels come from analog monitors, so they cross a domain
	logic [15:0] fault_meta_q;
	logic [15:0] fault_sync_q;
	logic [2:0]  clk_meta_q;
	logic [2:0]  clk_sync_q;

	// two stages; only the second stage is read by any logic
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			fault_meta_q <= 16'h0000;
			fault_sync_q <= 16'h0000;
			clk_meta_q   <= 3'h0;
			clk_sync_q   <= 3'h0;
		end else begin
			fault_meta_q <= i_supply_fault;
			fault_sync_q <= fault_meta_q;
			clk_meta_q   <= i_clock_fault;
			clk_sync_q   <= clk_meta_q;
		end
	end

	// ----------------------------------------------------------------
	// write decode
	// ----------------------------------------------------------------
	logic wr_supply;
	logic wr_clock;

	// a write to the progress register decodes to nothing
	assign wr_supply = i_bus.wr && (i_bus.addr == msr_pkg::ADDR_SUPPLY);
	assign wr_clock  = i_bus.wr && (i_bus.addr == msr_pkg::ADDR_CLOCK);

	// ----------------------------------------------------------------
	// completion counters
	// ----------------------------------------------------------------
	logic [1:0] aux_sequence_counter_q;
	logic [1:0] current_a_conversion_counter_q;
	logic [1:0] current_b_conversion_counter_q;
	logic       aux_sequence_running_q;

	// standby or disable wins over a completion in the same cycle
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			aux_sequence_counter_q <= msr_pkg::CNT_RESET;
		end else if (i_conv.standby || !i_conv.aux_enable) begin
			aux_sequence_counter_q <= msr_pkg::CNT_RESET;
		end else if (i_conv.aux_seq_done) begin
			// 2-bit add wraps 11b to 00b by itself
			aux_sequence_counter_q <=
				aux_sequence_counter_q + msr_pkg::CNT_STEP;
		end
	end

	// current converter a count
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			current_a_conversion_counter_q <= msr_pkg::CNT_RESET;
		end else if (i_conv.standby || !i_conv.current_a_enable) begin
			current_a_conversion_counter_q <= msr_pkg::CNT_RESET;
		end else if (i_conv.current_a_done) begin
			current_a_conversion_counter_q <=
				current_a_conversion_counter_q + msr_pkg::CNT_STEP;
		end
	end

	// current converter b count
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			current_b_conversion_counter_q <= msr_pkg::CNT_RESET;
		end else if (i_conv.standby || !i_conv.current_b_enable) begin
			current_b_conversion_counter_q <= msr_pkg::CNT_RESET;
		end else if (i_conv.current_b_done) begin
			current_b_conversion_counter_q <=
				current_b_conversion_counter_q + msr_pkg::CNT_STEP;
		end
	end

	// sequence running indicator, forced low when aux cannot run
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			aux_sequence_running_q <= 1'b0;
		end else begin
			aux_sequence_running_q <= i_conv.aux_seq_running
				&& i_conv.aux_enable && !i_conv.standby;
		end
	end

	// ----------------------------------------------------------------
	// sticky active-low fault flags
	// ----------------------------------------------------------------
	logic [15:0] supply_fault_status_q;
	logic [2:0]  clock_flags_q;

	// one loop covers every bit; bit index equals fault position,
	// so bit 15 is analog over, down to bit 0 digital ground open
	genvar g;
	generate
		for (g = 0; g < 16; g++) begin : g_supply
			always_ff @(posedge i_clock or negedge i_rst_n) begin
				if (!i_rst_n) begin
					supply_fault_status_q[g] <= msr_pkg::RST_SUPPLY[g];
				end else if (fault_sync_q[g]) begin
					// a fault seen in the clear cycle keeps the flag low
					supply_fault_status_q[g] <= 1'b0;
				end else if (wr_supply && i_bus.wdata[g]) begin
					supply_fault_status_q[g] <= 1'b1;
				end
			end
		end
		for (g = 0; g < 3; g++) begin : g_clock
			always_ff @(posedge i_clock or negedge i_rst_n) begin
				if (!i_rst_n) begin
					clock_flags_q[g] <= msr_pkg::RST_CLOCK[g];
				end else if (clk_sync_q[g]) begin
					clock_flags_q[g] <= 1'b0;
				end else if (wr_clock && i_bus.wdata[g]) begin
					clock_flags_q[g] <= 1'b1;
				end
			end
		end
	endgenerate
	// supply flags map through g_supply by bit position, clock flags through g_clock

	// ----------------------------------------------------------------
	// named supply fault flags
	// ----------------------------------------------------------------
	// each flag gets a name so the read word is assembled field by
	// field; each flag is read and written back through the same position
	// constant, so a swapped constant reads the same as one 16-bit copy
	logic        analog_supply_over_flag;
	logic        analog_supply_under_flag;
	logic        io_supply_over_flag;
	logic        io_supply_under_flag;
	logic        core_supply_over_flag;
	logic        core_supply_under_flag;
	logic        analog_supply_oscillation_flag;
	logic        io_supply_oscillation_flag;
	logic        core_supply_oscillation_flag;
	logic        analog_regulator_hot_flag;
	logic        io_regulator_hot_flag;
	logic        analog_regulator_limit_flag;
	logic        io_regulator_limit_flag;
	logic        analog_ground_first_open_flag;
	logic        analog_ground_second_open_flag;
	logic        digital_ground_open_flag;
	logic [15:0] supply_read_word;

	// analog supply voltage window
	assign analog_supply_over_flag =
		supply_fault_status_q[msr_pkg::POS_ANALOG_OV];
	assign analog_supply_under_flag =
		supply_fault_status_q[msr_pkg::POS_ANALOG_UV];
	// io supply voltage window
	assign io_supply_over_flag =
		supply_fault_status_q[msr_pkg::POS_IO_OV];
	assign io_supply_under_flag =
		supply_fault_status_q[msr_pkg::POS_IO_UV];
	// core supply voltage window
	assign core_supply_over_flag =
		supply_fault_status_q[msr_pkg::POS_CORE_OV];
	assign core_supply_under_flag =
		supply_fault_status_q[msr_pkg::POS_CORE_UV];
	// supply oscillation detectors
	assign analog_supply_oscillation_flag =
		supply_fault_status_q[msr_pkg::POS_ANALOG_OSC];
	assign io_supply_oscillation_flag =
		supply_fault_status_q[msr_pkg::POS_IO_OSC];
	assign core_supply_oscillation_flag =
		supply_fault_status_q[msr_pkg::POS_CORE_OSC];
	// regulator overtemperature warnings
	assign analog_regulator_hot_flag =
		supply_fault_status_q[msr_pkg::POS_ANALOG_HOT];
	assign io_regulator_hot_flag =
		supply_fault_status_q[msr_pkg::POS_IO_HOT];
	// regulator current limits
	assign analog_regulator_limit_flag =
		supply_fault_status_q[msr_pkg::POS_ANALOG_LIM];
	assign io_regulator_limit_flag =
		supply_fault_status_q[msr_pkg::POS_IO_LIM];
	// ground pin disconnect detectors
	assign analog_ground_first_open_flag =
		supply_fault_status_q[msr_pkg::POS_AGND1_OPEN];
	assign analog_ground_second_open_flag =
		supply_fault_status_q[msr_pkg::POS_AGND2_OPEN];
	assign digital_ground_open_flag =
		supply_fault_status_q[msr_pkg::POS_DIGITAL_GROUND_OPEN];

	// read word rebuilt from the named flags, one bit per position;
	// every bit is overwritten, the zero start only avoids a latch
	always_comb begin
		supply_read_word = 16'h0000;
		supply_read_word[msr_pkg::POS_ANALOG_OV] =
			analog_supply_over_flag;
		supply_read_word[msr_pkg::POS_ANALOG_UV] =
			analog_supply_under_flag;
		supply_read_word[msr_pkg::POS_IO_OV] =
			io_supply_over_flag;
		supply_read_word[msr_pkg::POS_IO_UV] =
			io_supply_under_flag;
		supply_read_word[msr_pkg::POS_CORE_OV] =
			core_supply_over_flag;
		supply_read_word[msr_pkg::POS_CORE_UV] =
			core_supply_under_flag;
		supply_read_word[msr_pkg::POS_ANALOG_OSC] =
			analog_supply_oscillation_flag;
		supply_read_word[msr_pkg::POS_IO_OSC] =
			io_supply_oscillation_flag;
		supply_read_word[msr_pkg::POS_CORE_OSC] =
			core_supply_oscillation_flag;
		supply_read_word[msr_pkg::POS_ANALOG_HOT] =
			analog_regulator_hot_flag;
		supply_read_word[msr_pkg::POS_IO_HOT] =
			io_regulator_hot_flag;
		supply_read_word[msr_pkg::POS_ANALOG_LIM] =
			analog_regulator_limit_flag;
		supply_read_word[msr_pkg::POS_IO_LIM] =
			io_regulator_limit_flag;
		supply_read_word[msr_pkg::POS_AGND1_OPEN] =
			analog_ground_first_open_flag;
		supply_read_word[msr_pkg::POS_AGND2_OPEN] =
			analog_ground_second_open_flag;
		supply_read_word[msr_pkg::POS_DIGITAL_GROUND_OPEN] =
			digital_ground_open_flag;
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	logic [15:0] progress_word;
	logic [15:0] read_word;

	// unused progress bits are tied to zero by construction
	always_comb begin
		progress_word = msr_pkg::RST_PROGRESS;
		progress_word[msr_pkg::POS_AUX_SEQ_CNT +: 2] =
			aux_sequence_counter_q;
		progress_word[msr_pkg::POS_CUR_A_CNT +: 2] =
			current_a_conversion_counter_q;
		progress_word[msr_pkg::POS_CUR_B_CNT +: 2] =
			current_b_conversion_counter_q;
		progress_word[msr_pkg::POS_AUX_RUN] = aux_sequence_running_q;
	end

	// unmapped addresses read zero
	always_comb begin
		case (i_bus.addr)
			msr_pkg::ADDR_PROGRESS: read_word = progress_word;
			msr_pkg::ADDR_SUPPLY:   read_word = supply_read_word;
			msr_pkg::ADDR_CLOCK:
				read_word = {msr_pkg::CLOCK_FIXED_BITS, clock_flags_q};
			default:                read_word = 16'h0000;
		endcase
	end

	// read data registered, valid only in the cycle after the strobe
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata <= 16'h0000;
		end else if (i_bus.rd) begin
			o_rdata <= read_word;
		end else begin
			o_rdata <= 16'h0000;
		end
	end

	// mirrored status for surrounding logic, one cycle behind
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_progress     <= msr_pkg::RST_PROGRESS;
			o_supply_flags <= msr_pkg::RST_SUPPLY;
		end else begin
			o_progress     <= progress_word;
			o_supply_flags <= supply_fault_status_q;
		end
	end
endmodule // msr_status_regs
`default_nettype wire

// ==== sim/msr_status_checker.sv ====
`default_nettype none
module msr_status_checker (
	input wire logic                  i_clock,
	input wire logic                  i_rst_n,
	input wire msr_pkg::msr_conv_type i_conv,
	input wire logic [15:0]           i_supply_fault,
	input wire logic [2:0]            i_clock_fault,
	input wire msr_pkg::msr_bus_type  i_bus,
	input wire logic [15:0]           o_rdata,
	input wire logic [15:0]           o_progress,
	input wire logic [15:0]           o_supply_flags
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------------
	// progress mirror lags its cause by two edges
	// ----------------------------------------------------------------
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	unused_zero_a: assert property (
		o_progress[13:12] == 2'h0 && o_progress[7:2] == 6'h0 && !o_progress[0])
		else $error("reserved progress bits set");
	standby_clear_a: assert property (
		i_conv.standby |-> ##2 o_progress == 16'h0)
		else $error("standby left progress nonzero");
	a_disable_a: assert property (
		!i_conv.current_a_enable |-> ##2 o_progress[11:10] == 2'h0)
		else $error("disabled counter a not cleared");
	a_step_a: assert property (
		i_conv.current_a_done && i_conv.current_a_enable && !i_conv.standby
		|-> ##2 o_progress[11:10] == $past(o_progress[11:10]) + 2'h1)
		else $error("counter a did not step");
	b_step_a: assert property (
		i_conv.current_b_done && i_conv.current_b_enable && !i_conv.standby
		|-> ##2 o_progress[9:8] == $past(o_progress[9:8]) + 2'h1)
		else $error("counter b did not step");
	aux_step_a: assert property (
		i_conv.aux_seq_done && i_conv.aux_enable && !i_conv.standby
		|-> ##2 o_progress[15:14] == $past(o_progress[15:14]) + 2'h1)
		else $error("aux counter did not step");
	running_bit_a: assert property (
		i_conv.aux_seq_running && i_conv.aux_enable && !i_conv.standby
		|-> ##2 o_progress[1])
		else $error("running bit low during sequence");
	// a flag may only return high after a host write two edges before
	flag_rise_a: assert property (
		|(o_supply_flags & ~$past(o_supply_flags))
		|-> $past(i_bus.wr && i_bus.addr == 8'h03, 2))
		else $error("fault flag restored without a write");
	fault_set_a: assert property (
		|i_supply_fault
		|-> ##4 (o_supply_flags & $past(i_supply_fault, 4)) == 16'h0)
		else $error("raw fault did not drop its flag");
	cover property (i_bus.wr && i_bus.addr == 8'h03);
	cover property (o_progress[11:10] == 2'h3);
	cover property (!o_supply_flags[0]);
endmodule // msr_status_checker

bind msr_status_regs msr_status_checker u_chk (.i_clock(i_clock),
	.i_rst_n(i_rst_n), .i_conv(i_conv), .i_supply_fault(i_supply_fault),
	.i_clock_fault(i_clock_fault), .i_bus(i_bus), .o_rdata(o_rdata),
	.o_progress(o_progress), .o_supply_flags(o_supply_flags));
`default_nettype wire

// ==== sim/msr_host_model.sv ====
`default_nettype none
module msr_host_model (
	input  wire logic                 i_clock,
	output var  msr_pkg::msr_bus_type o_bus,
	input  wire logic [15:0]          i_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial o_bus = '0;
	// idle cycle after each strobe, so a new call never double-drives
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge i_clock);
		o_bus <= '{a, d, 1'b1, 1'b0};
		@(posedge i_clock);
		o_bus <= '0;
	endtask
	// read data stand only in the cycle after the strobe edge
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge i_clock);
		o_bus <= '{a, 16'h0, 1'b0, 1'b1};
		@(posedge i_clock);
		o_bus <= '0;
		#1 d = i_rdata;
	endtask
endmodule // msr_host_model
`default_nettype wire

// ==== sim/tb_monitor_status_registers.sv ====
`default_nettype none
module tb_monitor_status_registers;
	timeunit 1ns;
	timeprecision 1ps;
	logic                  clk = 1'b0;
	logic                  rst_n = 1'b0;
	msr_pkg::msr_conv_type conv = '0;
	logic [15:0]           fault = 16'h0;
	logic [2:0]            cfault = 3'h0;
	msr_pkg::msr_bus_type  bus;
	logic [15:0]           rdata, progress, flags;
	int                    num_errors = 0;
	int                    num_checks = 0;
	int                    cyc = 0;
	always #20 clk = ~clk;
	msr_status_regs DUT (.i_clock(clk), .i_rst_n(rst_n), .i_conv(conv),
		.i_supply_fault(fault), .i_clock_fault(cfault), .i_bus(bus),
		.o_rdata(rdata), .o_progress(progress), .o_supply_flags(flags));
	msr_host_model host (.i_clock(clk), .o_bus(bus), .i_rdata(rdata));
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic cmp(input string n, input logic [15:0] e, s);
		num_checks++;
		if (s !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic chk(input logic [7:0] a, input logic [15:0] e);
		logic [15:0] d;
		host.rd(a, d);
		cmp($sformatf("reg %h", a), e, d);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// hang guard, well above the few hundred cycles the run needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 1000) begin
			num_errors++;
			tally_and_finish();
		end
	end
	initial begin
		tick(8);
		rst_n <= 1'b1;
		chk(8'h02, 16'h0000);
		chk(8'h03, 16'hffff);
		chk(8'h04, 16'hfc07);
		chk(8'h05, 16'h0000);
		host.wr(8'h02, 16'hffff);
		chk(8'h02, 16'h0000);
		conv <= 8'h4e; // all enabled, sequence running
		// five, three and two completions: counter a wraps past 11b
		for (int i = 0; i < 5; i++) begin
			@(posedge clk);
			conv.current_a_done <= 1'b1;
			conv.current_b_done <= (i < 3);
			conv.aux_seq_done <= (i < 2);
		end
		@(posedge clk);
		conv <= 8'h4e;
		chk(8'h02, 16'h8702);
		cmp("progress", 16'h8702, progress);
		conv.current_a_enable <= 1'b0;
		tick(1);
		conv.current_a_enable <= 1'b1;
		chk(8'h02, 16'h8302);
		conv <= 8'h0f;
		tick(1);
		conv <= 8'h0e;
		chk(8'h02, 16'h0000);
		// one-cycle pulse per fault, then zero write, then per-bit clear
		for (int k = 0; k < 16; k++) begin
			fault <= 16'h1 << k;
			tick(1);
			fault <= 16'h0;
			tick(3);
			chk(8'h03, ~(16'h1 << k));
			cmp("flags", ~(16'h1 << k), flags);
			host.wr(8'h03, 16'h0);
			chk(8'h03, ~(16'h1 << k));
			host.wr(8'h03, 16'h1 << k);
			chk(8'h03, 16'hffff);
		end
		cfault <= 3'h7;
		tick(1);
		cfault <= 3'h0;
		tick(3);
		chk(8'h04, 16'hfc00);
		host.wr(8'h04, 16'h0007);
		chk(8'h04, 16'hfc07);
		tally_and_finish();
	end
endmodule // tb_monitor_status_registers
`default_nettype wire
